//--- logic/csr_pkg.sv
package csr_pkg;

	// Register offsets on the two-wire link
	localparam logic [7:0] CSR_FAST_CHARGE_OFS     = 8'h03;
	localparam logic [7:0] CSR_TERMINATION_OFS     = 8'h04;
	localparam logic [7:0] CSR_BATTERY_VOLTAGE_OFS = 8'h05;

	// Values after reset
	localparam logic [7:0] CSR_FAST_CHARGE_RST     = 8'h18;
	localparam logic [7:0] CSR_TERMINATION_RST     = 8'h02;
	localparam logic [7:0] CSR_BATTERY_VOLTAGE_RST = 8'h78;
	localparam logic [7:0] CSR_UNMAPPED_READ       = 8'h00;

	// Field positions
	localparam int CSR_RANGE_BIT = 7;
	localparam int CSR_CODE_MSB  = 6;
	localparam int CSR_CODE_LSB  = 2;
	localparam int CSR_HALT_BIT  = 1;
	localparam int CSR_HIZ_BIT   = 0;
	localparam int CSR_CUTOFF_BIT = 1;
	localparam int CSR_VCODE_MSB = 7;
	localparam int CSR_VCODE_LSB = 1;

	// Charge current, mA
	localparam logic [9:0] CSR_CHG_LOW_BASE  = 10'h005;
	localparam logic [9:0] CSR_CHG_LOW_STEP  = 10'h001;
	localparam logic [9:0] CSR_CHG_LOW_MAX   = 10'h023;
	localparam logic [9:0] CSR_CHG_HIGH_BASE = 10'h028;
	localparam logic [9:0] CSR_CHG_HIGH_STEP = 10'h00a;
	localparam logic [9:0] CSR_CHG_HIGH_MAX  = 10'h12c;
	localparam logic [4:0] CSR_CHG_CODE_EXT  = 5'h1f;

	// End and pre-charge current, units of 500 uA
	localparam logic [6:0] CSR_END_LOW_BASE  = 7'h01;
	localparam logic [6:0] CSR_END_LOW_STEP  = 7'h01;
	localparam logic [6:0] CSR_END_LOW_MAX   = 7'h0a;
	localparam logic [6:0] CSR_END_HIGH_BASE = 7'h0c;
	localparam logic [6:0] CSR_END_HIGH_STEP = 7'h02;

	// Percent selections in external current mode
	localparam logic [5:0] CSR_PCT5_CODE  = 6'h01;
	localparam logic [5:0] CSR_PCT10_CODE = 6'h02;
	localparam logic [5:0] CSR_PCT15_CODE = 6'h04;
	localparam logic [5:0] CSR_PCT20_CODE = 6'h08;
	localparam logic [4:0] CSR_PCT5  = 5'h05;
	localparam logic [4:0] CSR_PCT10 = 5'h0a;
	localparam logic [4:0] CSR_PCT15 = 5'h0f;
	localparam logic [4:0] CSR_PCT20 = 5'h14;

	// Float voltage, mV
	localparam logic [12:0] CSR_FLT_BASE = 13'h0e10;
	localparam logic [12:0] CSR_FLT_STEP = 13'h000a;
	localparam logic [12:0] CSR_FLT_MAX  = 13'h122a;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} csr_state_t;

	typedef struct packed {
		logic [8:0]  charge_ma;
		logic        charge_from_pin;
		logic [6:0]  end_half_ma;
		logic        end_from_pin;
		logic        end_as_percent;
		logic [4:0]  end_percent;
		logic [12:0] float_mv;
		logic        charge_on;
		logic        high_impedance;
		logic        end_cutoff_allowed;
	} csr_setpoint_t;

endpackage

//--- logic/csr_decode.sv
`timescale 1ns/10ps
module csr_decode
	import csr_pkg::*;
(
	// Stored register values
	input  wire logic [7:0] fast_charge_control,
	input  wire logic [7:0] termination_precharge_control,
	input  wire logic [7:0] battery_voltage_control,
	// Synchronised conditions
	input  wire logic       charge_res_present,
	input  wire logic       end_res_present,
	input  wire logic       only_cc_cv_loop,
	// Effective settings
	output csr_setpoint_t   decoded
);

	always_comb begin
		logic [4:0]  charge_current_code;
		logic [4:0]  end_and_precharge_code;
		logic [5:0]  end_field;
		logic [9:0]  chg_raw;
		logic [6:0]  end_raw;
		logic [12:0] flt_raw;
		logic        ext_mode;
		chg_raw = 10'h000;
		end_raw = 7'h00;
		charge_current_code =
			fast_charge_control[CSR_CODE_MSB:CSR_CODE_LSB]; // R3
		end_and_precharge_code =
			termination_precharge_control[CSR_CODE_MSB:CSR_CODE_LSB]; // R12
		end_field = termination_precharge_control[CSR_RANGE_BIT:CSR_CODE_LSB];
		ext_mode = (charge_current_code == CSR_CHG_CODE_EXT); // R5

		if (fast_charge_control[CSR_RANGE_BIT]) begin
			chg_raw = CSR_CHG_HIGH_BASE
				+ 10'(charge_current_code) * CSR_CHG_HIGH_STEP; // R2
			if (chg_raw > CSR_CHG_HIGH_MAX)
				chg_raw = CSR_CHG_HIGH_MAX; // R4
		end else begin
			chg_raw = CSR_CHG_LOW_BASE
				+ 10'(charge_current_code) * CSR_CHG_LOW_STEP; // R1
			if (chg_raw > CSR_CHG_LOW_MAX)
				chg_raw = CSR_CHG_LOW_MAX; // R4
		end

		if (termination_precharge_control[CSR_RANGE_BIT]) begin
			end_raw = CSR_END_HIGH_BASE
				+ 7'(end_and_precharge_code) * CSR_END_HIGH_STEP; // R11
		end else begin
			end_raw = CSR_END_LOW_BASE
				+ 7'(end_and_precharge_code) * CSR_END_LOW_STEP; // R10
			if (end_raw > CSR_END_LOW_MAX)
				end_raw = CSR_END_LOW_MAX; // R13
		end

		flt_raw = CSR_FLT_BASE + 13'(battery_voltage_control[
			CSR_VCODE_MSB:CSR_VCODE_LSB]) * CSR_FLT_STEP; // R18
		if (flt_raw > CSR_FLT_MAX)
			flt_raw = CSR_FLT_MAX; // R19

		decoded.charge_ma = chg_raw[8:0];
		// Pin wins for an all-ones code, or with the resistor while the code still holds its reset value
		decoded.charge_from_pin = ext_mode
			| (charge_res_present
			& (fast_charge_control[CSR_CODE_MSB:CSR_CODE_LSB]
			== CSR_FAST_CHARGE_RST[CSR_CODE_MSB:CSR_CODE_LSB])); // R5 R17
		decoded.end_half_ma = end_raw; // R15
		decoded.end_from_pin = end_res_present
			& (end_field == CSR_TERMINATION_RST[
			CSR_RANGE_BIT:CSR_CODE_LSB]); // R17
		decoded.end_as_percent = ext_mode; // R7
		case (end_field)
			CSR_PCT5_CODE:  decoded.end_percent = CSR_PCT5; // R7
			CSR_PCT10_CODE: decoded.end_percent = CSR_PCT10;
			CSR_PCT15_CODE: decoded.end_percent = CSR_PCT15;
			CSR_PCT20_CODE: decoded.end_percent = CSR_PCT20;
			default:        decoded.end_percent = 5'h00;
		endcase
		if (!ext_mode)
			decoded.end_percent = 5'h00;
		decoded.float_mv = flt_raw;
		decoded.charge_on = ~fast_charge_control[CSR_HALT_BIT]; // R8
		decoded.high_impedance = fast_charge_control[CSR_HIZ_BIT]; // R9
		decoded.end_cutoff_allowed =
			termination_precharge_control[CSR_CUTOFF_BIT]
			& only_cc_cv_loop; // R14 R16
	end

endmodule

//--- logic/csr_top.sv
`timescale 1ns/10ps
// Behaviour
// R1: Low range: 5 mA plus code mA.
// R2: High range: 40 mA plus code times 10.
// R3: Charge code sits in bits 6..2.
// R4: Clamp charge at 35 or 300 mA.
// R5: All-ones charge code selects resistor pin current.
// R6: Host sets end code before all-ones.
// R7: External mode: one-hot end code in bits 5..2 gives percent.
// R8: Halt bit set stops charging.
// R9: High impedance bit selects high impedance.
// R10: Low end range: 500 uA steps.
// R11: High end range: 6 mA plus code mA.
// R12: End code sits in bits 6..2.
// R13: Clamp low end range at 5 mA.
// R14: Cutoff bit enables end-of-charge; resets to 1.
// R15: One end code serves end and pre-charge.
// R16: No ending unless constant current/voltage loop.
// R17: Pin resistors may override default settings.
// R18: Float code bits 7..1 over 3.6 V.
// R19: Clamp float voltage at 4.65 V.
// R20: Registers hold writes; reads return stored values.
module csr_top
	import csr_pkg::*;
#(
	// Arbitrary link address, not tied to any part
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	// Clock and reset
	input  wire logic    clk,
	input  wire logic    arst_n,
	// Two-wire host link, open drain
	input  wire logic    scl_in,
	input  wire logic    sda_in,
	output logic         sda_out,
	output logic         sda_drive_n,
	// Analog conditions, asynchronous
	input  wire logic    charge_res_present,
	input  wire logic    end_res_present,
	input  wire logic    only_cc_cv_loop,
	// Effective settings
	output csr_setpoint_t setpoint
);

	localparam int NSYNC = 5;

	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;
	logic [NSYNC-1:0] nxt_meta;
	logic [NSYNC-1:0] nxt_sync;
	logic             scl_last_ff;
	logic             sda_last_ff;
	logic             nxt_scl_last;
	logic             nxt_sda_last;

	csr_state_t       state_ff;
	csr_state_t       nxt_state;
	logic [7:0]       shift_ff;
	logic [7:0]       nxt_shift;
	logic [2:0]       bitcnt_ff;
	logic [2:0]       nxt_bitcnt;
	logic [7:0]       ptr_ff;
	logic [7:0]       nxt_ptr;
	logic             drive_n_ff;
	logic             nxt_drive_n;
	logic             ack_phase_ff;
	logic             nxt_ack_phase;
	logic             rw_ff;
	logic             nxt_rw;
	logic             mack_ff;
	logic             nxt_mack;

	logic [7:0]       fast_ff;
	logic [7:0]       term_ff;
	logic [7:0]       vbat_ff;
	logic [7:0]       nxt_fast;
	logic [7:0]       nxt_term;
	logic [7:0]       nxt_vbat;
	csr_setpoint_t    setpoint_ff;
	csr_setpoint_t    decoded;

	logic             scl_s;
	logic             sda_s;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_seen;
	logic             stop_seen;
	logic [7:0]       byte_in;
	logic [7:0]       rd_data;

	// Pins pass two flops before use
	always_comb begin
		nxt_meta = {only_cc_cv_loop, end_res_present, charge_res_present,
			sda_in, scl_in};
		nxt_sync = meta_ff;
		nxt_scl_last = sync_ff[0];
		nxt_sda_last = sync_ff[1];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= 5'h03;
			sync_ff <= 5'h03;
			scl_last_ff <= 1'b1;
			sda_last_ff <= 1'b1;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			scl_last_ff <= nxt_scl_last;
			sda_last_ff <= nxt_sda_last;
		end
	end

	assign scl_s = sync_ff[0];
	assign sda_s = sync_ff[1];
	assign scl_rise = scl_s & ~scl_last_ff;
	assign scl_fall = ~scl_s & scl_last_ff;
	// Data edges while the clock stays high frame a transaction
	assign start_seen = scl_s & scl_last_ff & sda_last_ff & ~sda_s;
	assign stop_seen = scl_s & scl_last_ff & ~sda_last_ff & sda_s;
	assign byte_in = {shift_ff[6:0], sda_s};

	// Reads show stored bytes, never the clamped result
	always_comb begin
		case (ptr_ff)
			CSR_FAST_CHARGE_OFS:     rd_data = fast_ff; // R20
			CSR_TERMINATION_OFS:     rd_data = term_ff; // R20
			CSR_BATTERY_VOLTAGE_OFS: rd_data = vbat_ff; // R20
			default:                 rd_data = CSR_UNMAPPED_READ;
		endcase
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_shift = shift_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_ptr = ptr_ff;
		nxt_drive_n = drive_n_ff;
		nxt_ack_phase = ack_phase_ff;
		nxt_rw = rw_ff;
		nxt_mack = mack_ff;
		nxt_fast = fast_ff;
		nxt_term = term_ff;
		nxt_vbat = vbat_ff;
		if (start_seen) begin
			nxt_state = ST_ADDR;
			nxt_bitcnt = 3'h0;
			nxt_drive_n = 1'b1;
			nxt_ack_phase = 1'b0;
		end else if (stop_seen) begin
			nxt_state = ST_IDLE;
			nxt_drive_n = 1'b1;
			nxt_ack_phase = 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					nxt_drive_n = 1'b1;
				end
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						nxt_shift = byte_in;
						nxt_bitcnt = 3'(bitcnt_ff + 3'h1);
						if (bitcnt_ff == 3'h7) begin
							case (state_ff)
								ST_ADDR: begin
									if (byte_in[7:1] == DEV_ADDR) begin
										nxt_state = ST_ADDR_ACK;
										nxt_rw = byte_in[0];
									end else begin
										// Other targets: stay silent
										nxt_state = ST_IDLE;
									end
								end
								ST_PTR: begin
									nxt_ptr = byte_in;
									nxt_state = ST_PTR_ACK;
								end
								default: begin
									case (ptr_ff)
										CSR_FAST_CHARGE_OFS:
											nxt_fast = byte_in; // R20
										CSR_TERMINATION_OFS:
											nxt_term = byte_in; // R20
										CSR_BATTERY_VOLTAGE_OFS:
											nxt_vbat = byte_in; // R20
										default: ;
									endcase
									nxt_ptr = 8'(ptr_ff + 8'h01);
									nxt_state = ST_WDATA_ACK;
								end
							endcase
						end
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						if (!ack_phase_ff) begin
							nxt_drive_n = 1'b0;
							nxt_ack_phase = 1'b1;
						end else begin
							nxt_drive_n = 1'b1;
							nxt_ack_phase = 1'b0;
							nxt_bitcnt = 3'h0;
							if (state_ff == ST_ADDR_ACK && rw_ff) begin
								nxt_state = ST_RDATA;
								nxt_shift = rd_data;
								nxt_drive_n = rd_data[7];
							end else if (state_ff == ST_ADDR_ACK) begin
								nxt_state = ST_PTR;
							end else begin
								nxt_state = ST_WDATA;
							end
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bitcnt_ff == 3'h7) begin
							nxt_drive_n = 1'b1;
							nxt_ptr = 8'(ptr_ff + 8'h01);
							nxt_state = ST_RDATA_ACK;
						end else begin
							nxt_shift = {shift_ff[6:0], 1'b0};
							nxt_drive_n = shift_ff[6];
							nxt_bitcnt = 3'(bitcnt_ff + 3'h1);
						end
					end
				end
				ST_RDATA_ACK: begin
					if (scl_rise) begin
						nxt_mack = ~sda_s;
					end else if (scl_fall) begin
						nxt_bitcnt = 3'h0;
						if (mack_ff) begin
							nxt_state = ST_RDATA;
							nxt_shift = rd_data;
							nxt_drive_n = rd_data[7];
						end else begin
							// Host refused more data; wait for stop
							nxt_state = ST_IDLE;
						end
					end
				end
				default: begin
					nxt_state = ST_IDLE;
					nxt_drive_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
			shift_ff <= 8'h00;
			bitcnt_ff <= 3'h0;
			ptr_ff <= 8'h00;
			drive_n_ff <= 1'b1;
			ack_phase_ff <= 1'b0;
			rw_ff <= 1'b0;
			mack_ff <= 1'b0;
			fast_ff <= CSR_FAST_CHARGE_RST;
			term_ff <= CSR_TERMINATION_RST; // R14
			vbat_ff <= CSR_BATTERY_VOLTAGE_RST;
		end else begin
			state_ff <= nxt_state;
			shift_ff <= nxt_shift;
			bitcnt_ff <= nxt_bitcnt;
			ptr_ff <= nxt_ptr;
			drive_n_ff <= nxt_drive_n;
			ack_phase_ff <= nxt_ack_phase;
			rw_ff <= nxt_rw;
			mack_ff <= nxt_mack;
			fast_ff <= nxt_fast;
			term_ff <= nxt_term;
			vbat_ff <= nxt_vbat;
		end
	end

	// R6 is the host's duty; decoding follows whatever order it uses
	csr_decode u_decode (
		.fast_charge_control           (fast_ff),
		.termination_precharge_control (term_ff),
		.battery_voltage_control       (vbat_ff),
		.charge_res_present            (sync_ff[2]),
		.end_res_present               (sync_ff[3]),
		.only_cc_cv_loop               (sync_ff[4]),
		.decoded                       (decoded)
	);

	// Registered so the analog side never sees decode glitches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			setpoint_ff <= '0;
		end else begin
			setpoint_ff <= decoded;
		end
	end

	assign setpoint = setpoint_ff;
	assign sda_out = 1'b0;
	assign sda_drive_n = drive_n_ff;

endmodule

//--- sim/csr_top_asserts.sv
`timescale 1ns/10ps
module csr_top_chk
	import csr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	// Clock and reset
	input wire logic          clk,
	input wire logic          arst_n,
	// Link pins
	input wire logic          scl_in,
	input wire logic          sda_in,
	input wire logic          sda_out,
	input wire logic          sda_drive_n,
	// Conditions
	input wire logic          charge_res_present,
	input wire logic          end_res_present,
	input wire logic          only_cc_cv_loop,
	// Settings
	input wire csr_setpoint_t setpoint
);
	logic [1:0] live_ff;
	logic [1:0] nxt_live;

	// Setpoint is zero during reset, so checks wait one edge
	always_comb begin
		nxt_live = (live_ff == 2'h3) ? live_ff : live_ff + 2'h1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			live_ff <= 2'h0;
		end else begin
			live_ff <= nxt_live;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	reset_decode_a: assert property (
		live_ff == 2'h1 |-> setpoint.charge_ma == 9'h00b
		&& setpoint.end_half_ma == 7'h01 && setpoint.charge_on
		&& setpoint.float_mv == 13'h1068 && !setpoint.high_impedance)
		else $error("Setpoint differs from reset decode");
	charge_low_a: assert property (
		live_ff != 2'h0 |-> setpoint.charge_ma >= 9'h005
		&& !(setpoint.charge_ma inside {[9'h024:9'h027]}))
		else $error("Charge current outside low range");
	charge_high_a: assert property (
		live_ff != 2'h0 && setpoint.charge_ma >= 9'h028
		|-> setpoint.charge_ma <= 9'h12c
		&& setpoint.charge_ma % 9'h00a == 9'h000)
		else $error("Charge current outside high range");
	end_range_a: assert property (
		live_ff != 2'h0 |-> setpoint.end_half_ma inside {[7'h01:7'h0a]}
		|| (setpoint.end_half_ma inside {[7'h0c:7'h4a]}
		&& !setpoint.end_half_ma[0]))
		else $error("End current outside range");
	float_range_a: assert property (
		live_ff != 2'h0 |-> setpoint.float_mv inside {[13'h0e10:13'h122a]}
		&& setpoint.float_mv % 13'h00a == 13'h0000)
		else $error("Float voltage outside range");
	pct_only_a: assert property (
		!setpoint.end_as_percent |-> setpoint.end_percent == 5'h00)
		else $error("Percent shown outside external mode");
	pct_value_a: assert property (
		setpoint.end_as_percent |-> setpoint.charge_from_pin
		&& setpoint.end_percent inside {5'h00, 5'h05, 5'h0a, 5'h0f, 5'h14})
		else $error("Bad percent in external mode");
	loop_gate_a: assert property (
		!only_cc_cv_loop [*4] |-> !setpoint.end_cutoff_allowed)
		else $error("Cutoff allowed under another loop");
	pin_reset_a: assert property (
		setpoint.end_from_pin |-> setpoint.end_half_ma == 7'h01)
		else $error("End pin override with changed code");
endmodule

bind csr_top csr_top_chk #(.DEV_ADDR(DEV_ADDR)) u_chk (
	.clk               (clk),
	.arst_n            (arst_n),
	.scl_in            (scl_in),
	.sda_in            (sda_in),
	.sda_out           (sda_out),
	.sda_drive_n       (sda_drive_n),
	.charge_res_present(charge_res_present),
	.end_res_present   (end_res_present),
	.only_cc_cv_loop   (only_cc_cv_loop),
	.setpoint          (setpoint)
);

//--- sim/csr_host_model.sv
`timescale 1ns/10ps
module csr_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	// Clock
	input  wire logic clk,
	// Link pins
	input  wire logic sda_drive_n,
	input  wire logic sda_out,
	output logic      scl_in,
	output logic      sda_in
);
	logic       host_low;
	logic [7:0] junk;
	logic       a0;
	logic       a1;
	logic       a2;

	// Pulled up: a released line reads 1; a driven line shows sda_out
	assign sda_in = !host_low && (sda_drive_n || sda_out);

	initial begin
		scl_in = 1'b1;
		host_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic bit_io(input logic b, output logic r);
		host_low = !b;
		tick(4);
		scl_in = 1'b1;
		tick(4);
		r = sda_in;
		tick(4);
		scl_in = 1'b0;
		tick(4);
	endtask

	// Also serves as repeated start
	task automatic start();
		host_low = 1'b0;
		tick(4);
		scl_in = 1'b1;
		tick(8);
		host_low = 1'b1;
		tick(8);
		scl_in = 1'b0;
		tick(4);
	endtask

	task automatic stop();
		host_low = 1'b1;
		tick(4);
		scl_in = 1'b1;
		tick(8);
		host_low = 1'b0;
		tick(8);
	endtask

	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(last, r);
		ack = !r;
	endtask

	task automatic wr(input logic [6:0] dev, input logic [7:0] ofs,
		input logic [7:0] d, output logic ok);
		start();
		xfer({dev, 1'b0}, 1'b1, junk, a0);
		xfer(ofs, 1'b1, junk, a1);
		xfer(d, 1'b1, junk, a2);
		stop();
		ok = a0 && a1 && a2;
	endtask

	task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, junk, a0);
		xfer(ofs, 1'b1, junk, a1);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, junk, a2);
		xfer(8'hff, 1'b1, d, a0);
		stop();
	endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
	import csr_pkg::*;
	localparam logic [6:0] DEV = 7'h2a;
	logic          clk;
	logic          arst_n;
	logic          scl_in;
	logic          sda_in;
	logic          sda_out;
	logic          sda_drive_n;
	logic          charge_res_present;
	logic          end_res_present;
	logic          only_cc_cv_loop;
	csr_setpoint_t setpoint;
	logic          ok;
	logic [7:0]    q;
	int            errors;
	int            cmp_count;

	csr_top #(.DEV_ADDR(DEV)) u_csr_top (
		.clk               (clk),
		.arst_n            (arst_n),
		.scl_in            (scl_in),
		.sda_in            (sda_in),
		.sda_out           (sda_out),
		.sda_drive_n       (sda_drive_n),
		.charge_res_present(charge_res_present),
		.end_res_present   (end_res_present),
		.only_cc_cv_loop   (only_cc_cv_loop),
		.setpoint          (setpoint)
	);

	csr_host_model #(.DEV_ADDR(DEV)) u_host (
		.clk        (clk),
		.sda_drive_n(sda_drive_n),
		.sda_out    (sda_out),
		.scl_in     (scl_in),
		.sda_in     (sda_in)
	);

	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic finish_test();
		if (errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic do_reset();
		arst_n = 1'b0;
		tick(12);
		arst_n = 1'b1;
		tick(4);
	endtask

	task automatic wreg(input logic [7:0] o, input logic [7:0] d);
		u_host.wr(DEV, o, d, ok);
		`CHK(ok, 1'b1)
	endtask

	task automatic rdc(input logic [7:0] o, input logic [7:0] e);
		u_host.rd(o, q);
		`CHK(q, e)
	endtask

	task automatic t_reset_vals();
		charge_res_present = 1'b1;
		end_res_present = 1'b1;
		tick(8);
		`CHK(setpoint.charge_from_pin, 1'b1)
		`CHK(setpoint.end_from_pin, 1'b1)
		charge_res_present = 1'b0;
		end_res_present = 1'b0;
		`CHK(setpoint.charge_ma, 9'h00b)
		`CHK(setpoint.float_mv, 13'h1068)
		rdc(8'h03, 8'h18);
		rdc(8'h04, 8'h02);
		rdc(8'h05, 8'h78);
	endtask

	task automatic t_charge();
		logic [7:0] v [9] = '{8'h00, 8'h78, 8'h7c, 8'h40, 8'h80, 8'h98,
			8'hec, 8'h02, 8'h01};
		logic [9:0] e;
		foreach (v[i]) begin
			wreg(8'h03, v[i]);
			e = v[i][7] ? 10'h028 + 10'h00a * v[i][6:2]
				: 10'h005 + v[i][6:2];
			e = (v[i][7] && e > 10'h12c) ? 10'h12c : e;
			e = (!v[i][7] && e > 10'h023) ? 10'h023 : e;
			`CHK(setpoint.charge_ma, e[8:0])
			`CHK(setpoint.charge_from_pin, &v[i][6:2])
			`CHK(setpoint.charge_on, !v[i][1])
			`CHK(setpoint.high_impedance, v[i][0])
			rdc(8'h03, v[i]);
		end
	endtask

	task automatic t_end();
		logic [7:0] v [7] = '{8'h00, 8'h24, 8'h28, 8'h7c, 8'h80, 8'hfc,
			8'h02};
		logic [6:0] e;
		foreach (v[i]) begin
			wreg(8'h04, v[i]);
			e = v[i][7] ? 7'h0c + 7'h02 * v[i][6:2] : 7'h01 + v[i][6:2];
			e = (!v[i][7] && e > 7'h0a) ? 7'h0a : e;
			`CHK(setpoint.end_half_ma, e)
			`CHK(setpoint.end_cutoff_allowed, v[i][1])
			rdc(8'h04, v[i]);
		end
		only_cc_cv_loop = 1'b0;
		tick(8);
		`CHK(setpoint.end_cutoff_allowed, 1'b0)
		only_cc_cv_loop = 1'b1;
		tick(8);
		`CHK(setpoint.end_cutoff_allowed, 1'b1)
	endtask

	task automatic t_pct();
		for (int k = 0; k < 4; k++) begin
			wreg(8'h04, 8'h04 << k);
			if (k == 0) begin
				wreg(8'h03, 8'h7c);
			end
			`CHK(setpoint.end_as_percent, 1'b1)
			`CHK(setpoint.end_percent, 5'h05 * (k + 1))
			`CHK(setpoint.charge_from_pin, 1'b1)
		end
		wreg(8'h03, 8'h00);
		`CHK(setpoint.end_percent, 5'h00)
	endtask

	task automatic t_float();
		logic [7:0] v [6] = '{8'h00, 8'h02, 8'h80, 8'hd2, 8'hd4, 8'hfe};
		logic [12:0] e;
		foreach (v[i]) begin
			wreg(8'h05, v[i]);
			e = 13'h0e10 + 13'h00a * v[i][7:1];
			e = (e > 13'h122a) ? 13'h122a : e;
			`CHK(setpoint.float_mv, e)
			rdc(8'h05, v[i]);
		end
	endtask

	task automatic t_link();
		u_host.wr(DEV ^ 7'h01, 8'h05, 8'h00, ok);
		`CHK(ok, 1'b0)
		rdc(8'h05, 8'hfe);
		wreg(8'h07, 8'haa);
		rdc(8'h07, 8'h00);
	endtask

	initial begin
		arst_n = 1'b0;
		charge_res_present = 1'b0;
		end_res_present = 1'b0;
		only_cc_cv_loop = 1'b1;
		errors = 0;
		cmp_count = 0;
		do_reset();
		t_reset_vals();
		t_charge();
		t_end();
		t_pct();
		t_float();
		t_link();
		// Second reset mid-run must restore every register
		do_reset();
		t_reset_vals();
		finish_test();
	end

	initial begin
		#400000;
		errors++;
		finish_test();
	end
endmodule
